// file: acr_map.vh
`ifndef ACR_MAP_VH
`define ACR_MAP_VH
// =====================================================
// Register offsets
`define ACR_OFS_SOFT_RESET 8'h00
`define ACR_OFS_MODE_DIV 8'h31
`define ACR_OFS_ROUTE_12 8'h3A
`define ACR_OFS_ROUTE_34 8'h3B
`define ACR_OFS_TRIM 8'h55
// =====================================================
// Field positions
`define ACR_SOFT_RESET_BIT 0
`define ACR_CHAN_LSB 0
`define ACR_CHAN_MSB 2
`define ACR_DIV_LSB 8
`define ACR_DIV_MSB 9
`define ACR_ROUTE_LO_LSB 0
`define ACR_ROUTE_LO_MSB 4
`define ACR_ROUTE_HI_LSB 8
`define ACR_ROUTE_HI_MSB 12
`define ACR_TRIM_LSB 0
`define ACR_TRIM_MSB 5
// =====================================================
// Mode codes and reset values
`define ACR_MODE_SINGLE 3'h1
`define ACR_MODE_DUAL 3'h2
`define ACR_MODE_QUAD 3'h4
`define ACR_RST_CHAN 3'h4
`define ACR_RST_DIV 2'h0
`define ACR_ROUTE_IN1 5'h02
`define ACR_ROUTE_IN2 5'h04
`define ACR_ROUTE_IN3 5'h08
`define ACR_ROUTE_IN4 5'h10
`define ACR_RST_TRIM 6'h20
`define ACR_RST_BRANCHES 4'h2
`define ACR_RST_CHAN_MAP 8'hE4
`define ACR_RST_ROUTE_IDX 8'hE4
`endif

// file: acr_clk_divider.v
`timescale 1ns/1ps
`default_nettype none
// =====================================================
// Sampling clock enable divider
module acr_clk_divider (
    input wire ref_clk,
    input wire srst,
    input wire [1:0] divCode,
    output reg sampleTick
);
    reg [2:0] count_q;
    wire [2:0] lastCount;
    // Divide by 1, 2, 4 or 8
    assign lastCount = (3'h1 << divCode) - 3'h1;
    always @(posedge ref_clk) begin
        if (srst) begin
            count_q <= 3'h0;
            sampleTick <= 1'b0;
        end else if (count_q >= lastCount) begin
            count_q <= 3'h0;
            sampleTick <= 1'b1;
        end else begin
            count_q <= count_q + 3'h1;
            sampleTick <= 1'b0;
        end
    end
endmodule // acr_clk_divider
`default_nettype wire

// file: acr_config_regs.v
`timescale 1ns/1ps
`default_nettype none
`include "acr_map.vh"
module acr_config_regs (
    input wire ref_clk,
    input wire srst,
    input wire wrStrobe,
    input wire rdStrobe,
    input wire [7:0] regAddr,
    input wire [15:0] wrData,
    output reg [15:0] rdData,
    output reg rdValid,
    output reg [2:0] chanMode,
    output reg [1:0] clkDivCode,
    output wire sampleTick,
    output reg [3:0] branchesPerChan,
    output reg [7:0] chanOfConv,
    output reg [4:0] route_sel_conv_one,
    output reg [4:0] route_sel_conv_two,
    output reg [4:0] route_sel_conv_three,
    output reg [4:0] route_sel_conv_four,
    output reg [7:0] routeIndex,
    output reg [5:0] full_scale_trim_code,
    output reg [6:0] trimMagnitude,
    output reg trimNegative
);
    // =====================================================
    // Helpers
    // Routing code to input index 0..3; forbidden codes fall back to input one
    function [1:0] routeToIndex;
        input [4:0] code;
        begin
            case (code)
                `ACR_ROUTE_IN2: routeToIndex = 2'h1;
                `ACR_ROUTE_IN3: routeToIndex = 2'h2;
                `ACR_ROUTE_IN4: routeToIndex = 2'h3;
                default: routeToIndex = 2'h0;
            endcase
        end
    endfunction

    // Address decode shared by the write and read paths, one bit per register
    function [4:0] decodeAddr;
        input [7:0] addr;
        begin
            case (addr)
                `ACR_OFS_SOFT_RESET: decodeAddr = 5'h01;
                `ACR_OFS_MODE_DIV: decodeAddr = 5'h02;
                `ACR_OFS_ROUTE_12: decodeAddr = 5'h04;
                `ACR_OFS_ROUTE_34: decodeAddr = 5'h08;
                `ACR_OFS_TRIM: decodeAddr = 5'h10;
                default: decodeAddr = 5'h00;
            endcase
        end
    endfunction

    wire [4:0] wrHit;
    wire [4:0] rdHit;
    wire softReset;
    wire wrMode;
    wire wrRoute12;
    wire wrRoute34;
    wire wrTrim;
    // Undefined offsets decode to no hit, so stray writes change nothing
    assign wrHit = wrStrobe ? decodeAddr(regAddr) : 5'h00;
    assign rdHit = decodeAddr(regAddr);
    assign softReset = wrHit[0] && wrData[`ACR_SOFT_RESET_BIT];
    assign wrMode = wrHit[1];
    assign wrRoute12 = wrHit[2];
    assign wrRoute34 = wrHit[3];
    assign wrTrim = wrHit[4];

    // =====================================================
    // Per-converter route plumbing
    // Converters one and three use the low half of their word, two and four the high half
    wire [19:0] routeFields;
    wire [19:0] routeWrValue;
    wire [3:0] routeWrEnable;
    wire [7:0] routeIndexNext;
    genvar conv;
    assign routeFields = {route_sel_conv_four, route_sel_conv_three, route_sel_conv_two, route_sel_conv_one};
    generate
        for (conv = 0; conv < 4; conv = conv + 1) begin : gConvRoute
            // Bit 0 of each route field is forced low so it is always zero
            if (conv % 2 == 0) begin : gLow
                assign routeWrValue[5*conv+4:5*conv] = {wrData[`ACR_ROUTE_LO_MSB:`ACR_ROUTE_LO_LSB+1], 1'b0};
            end else begin : gHigh
                assign routeWrValue[5*conv+4:5*conv] = {wrData[`ACR_ROUTE_HI_MSB:`ACR_ROUTE_HI_LSB+1], 1'b0};
            end
            assign routeWrEnable[conv] = (conv < 2) ? wrRoute12 : wrRoute34;
            assign routeIndexNext[2*conv+1:2*conv] = routeToIndex(routeFields[5*conv+4:5*conv]);
        end
    endgenerate

    // =====================================================
    // Register bank
    // Soft reset bit is never stored, so it reads back as cleared at once
    always @(posedge ref_clk) begin
        // Both resets share one branch so they restore identical defaults
        if (srst || softReset) begin
            chanMode <= `ACR_RST_CHAN;
            clkDivCode <= `ACR_RST_DIV;
            route_sel_conv_one <= `ACR_ROUTE_IN1;
            route_sel_conv_two <= `ACR_ROUTE_IN2;
            route_sel_conv_three <= `ACR_ROUTE_IN3;
            route_sel_conv_four <= `ACR_ROUTE_IN4;
            full_scale_trim_code <= `ACR_RST_TRIM;
        end else begin
            if (wrMode) begin
                chanMode <= wrData[`ACR_CHAN_MSB:`ACR_CHAN_LSB];
                clkDivCode <= wrData[`ACR_DIV_MSB:`ACR_DIV_LSB];
            end
            if (routeWrEnable[0]) begin
                route_sel_conv_one <= routeWrValue[4:0];
            end
            if (routeWrEnable[1]) begin
                route_sel_conv_two <= routeWrValue[9:5];
            end
            if (routeWrEnable[2]) begin
                route_sel_conv_three <= routeWrValue[14:10];
            end
            if (routeWrEnable[3]) begin
                route_sel_conv_four <= routeWrValue[19:15];
            end
            if (wrTrim) begin
                full_scale_trim_code <= wrData[`ACR_TRIM_MSB:`ACR_TRIM_LSB];
            end
        end
    end

    // =====================================================
    // Readback, one cycle after the strobe; unmapped reads return zero
    always @(posedge ref_clk) begin
        if (srst) begin
            rdData <= 16'h0000;
            rdValid <= 1'b0;
        end else begin
            rdValid <= rdStrobe;
            if (rdStrobe) begin
                // Registered read data stands until the next read
                case (rdHit)
                    5'h02: rdData <= {6'h00, clkDivCode, 5'h00, chanMode};
                    5'h04: rdData <= {3'h0, route_sel_conv_two, 3'h0, route_sel_conv_one};
                    5'h08: rdData <= {3'h0, route_sel_conv_four, 3'h0, route_sel_conv_three};
                    5'h10: rdData <= {10'h000, full_scale_trim_code};
                    default: rdData <= 16'h0000;
                endcase
            end
        end
    end

    // =====================================================
    // Interleave and cross point mapping, registered one cycle behind the fields
    // Undefined mode codes are treated as quad so the core never sees an illegal map
    always @(posedge ref_clk) begin
        if (srst) begin
            branchesPerChan <= `ACR_RST_BRANCHES;
            chanOfConv <= `ACR_RST_CHAN_MAP;
            routeIndex <= `ACR_RST_ROUTE_IDX;
        end else begin
            case (chanMode)
                `ACR_MODE_SINGLE: begin
                    branchesPerChan <= 4'h8;
                    chanOfConv <= 8'h00;
                end
                `ACR_MODE_DUAL: begin
                    branchesPerChan <= 4'h4;
                    chanOfConv <= 8'h50;
                end
                default: begin
                    branchesPerChan <= 4'h2;
                    chanOfConv <= 8'hE4;
                end
            endcase
            routeIndex <= routeIndexNext;
        end
    end

    // =====================================================
    // Trim converter drive: offset-binary code split into sign and step count
    // Codes below 32 take 32 minus the code as step count, which keeps the response monotonic across all 64 codes
    always @(posedge ref_clk) begin
        if (srst) begin
            trimMagnitude <= 7'h00;
            trimNegative <= 1'b0;
        end else begin
            trimNegative <= ~full_scale_trim_code[5];
            trimMagnitude <= full_scale_trim_code[5] ? {2'h0, full_scale_trim_code[4:0]} :
                             (7'h20 - {1'b0, full_scale_trim_code});
        end
    end

    // Only srst restarts the divider count; a soft reset just returns its code to divide by one
    acr_clk_divider uDivider (
        .ref_clk(ref_clk),
        .srst(srst),
        .divCode(clkDivCode),
        .sampleTick(sampleTick)
    );
endmodule // acr_config_regs
`default_nettype wire

// file: acr_config_regs_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// Checker
module acr_config_regs_asserts (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic wrStrobe,
    input wire logic [7:0] regAddr,
    input wire logic [15:0] wrData,
    input wire logic [2:0] chanMode,
    input wire logic [1:0] clkDivCode,
    input wire logic [3:0] branchesPerChan,
    input wire logic [7:0] chanOfConv,
    input wire logic [4:0] route_sel_conv_one,
    input wire logic [4:0] route_sel_conv_two,
    input wire logic [4:0] route_sel_conv_three,
    input wire logic [4:0] route_sel_conv_four,
    input wire logic [5:0] full_scale_trim_code,
    input wire logic trimNegative
);
default clocking cb @(posedge ref_clk); endclocking
default disable iff (srst);
sequence s_wr(logic [7:0] a); wrStrobe && regAddr == a; endsequence
sequence s_dflt;
    chanMode == 3'h4 && clkDivCode == 2'h0 && full_scale_trim_code == 6'h20 && route_sel_conv_one == 5'h02
    && route_sel_conv_two == 5'h04 && route_sel_conv_three == 5'h08 && route_sel_conv_four == 5'h10;
endsequence
property p_soft; s_wr(8'h00) ##0 wrData[0] |=> s_dflt; endproperty
a_soft: assert property (p_soft) else $error("soft reset missed");
property p_por; $fell(srst) |-> s_dflt; endproperty
a_por: assert property (p_por) else $error("reset defaults wrong");
property p_mode; s_wr(8'h31) |=> chanMode == $past(wrData[2:0]) && clkDivCode == $past(wrData[9:8]); endproperty
a_mode: assert property (p_mode) else $error("mode write lost");
property p_branch; 1 |=> branchesPerChan == ($past(chanMode) == 3'h1 ? 4'h8 : $past(chanMode) == 3'h2 ? 4'h4 : 4'h2);
endproperty
a_branch: assert property (p_branch) else $error("branch count wrong");
property p_map; 1 |=> chanOfConv == ($past(chanMode) == 3'h1 ? 8'h00 : $past(chanMode) == 3'h2 ? 8'h50 : 8'hE4);
endproperty
a_map: assert property (p_map) else $error("channel map wrong");
property p_r12; s_wr(8'h3A) |=> route_sel_conv_one == {$past(wrData[4:1]), 1'b0}
    && route_sel_conv_two == {$past(wrData[12:9]), 1'b0}; endproperty
a_r12: assert property (p_r12) else $error("route one two wrong");
property p_r34; s_wr(8'h3B) |=> route_sel_conv_three == {$past(wrData[4:1]), 1'b0}
    && route_sel_conv_four == {$past(wrData[12:9]), 1'b0}; endproperty
a_r34: assert property (p_r34) else $error("route three four wrong");
property p_trim; s_wr(8'h55) |=> full_scale_trim_code == $past(wrData[5:0]); endproperty
a_trim: assert property (p_trim) else $error("trim write lost");
property p_sign; 1 |=> trimNegative == ($past(full_scale_trim_code) < 6'h20); endproperty
a_sign: assert property (p_sign) else $error("trim sign wrong");
endmodule // acr_config_regs_asserts
bind acr_config_regs acr_config_regs_asserts u_chk (.ref_clk(ref_clk), .srst(srst), .wrStrobe(wrStrobe),
    .regAddr(regAddr), .wrData(wrData), .chanMode(chanMode), .clkDivCode(clkDivCode),
    .branchesPerChan(branchesPerChan), .chanOfConv(chanOfConv), .route_sel_conv_one(route_sel_conv_one),
    .route_sel_conv_two(route_sel_conv_two), .route_sel_conv_three(route_sel_conv_three),
    .route_sel_conv_four(route_sel_conv_four), .full_scale_trim_code(full_scale_trim_code),
    .trimNegative(trimNegative));
`default_nettype wire

// file: acr_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// Control port host; callers enter and leave just after a rising edge
module acr_host_model (
    input wire logic ref_clk,
    output logic wrStrobe,
    output logic rdStrobe,
    output logic [7:0] regAddr,
    output logic [15:0] wrData,
    input wire logic [15:0] rdData,
    input wire logic rdValid
);
initial begin
    {wrStrobe, rdStrobe, regAddr, wrData} = '0;
end
// Only defined addresses, undefined bits zero
task wr(input logic [7:0] a, input logic [15:0] d);
    regAddr = a;
    wrData = d;
    wrStrobe = 1'b1;
    @(posedge ref_clk);
    #1 wrStrobe = 1'b0;
    wrData = ~d;
    // One idle edge keeps back-to-back calls from toggling a strobe twice in one time step
    @(posedge ref_clk);
    #1;
endtask
task rd(input logic [7:0] a, output logic [15:0] q);
    regAddr = a;
    rdStrobe = 1'b1;
    @(posedge ref_clk);
    #1 rdStrobe = 1'b0;
    regAddr = ~a;
    q = rdValid === 1'b1 ? rdData : 16'hDEAD;
    @(posedge ref_clk);
    #1;
endtask
endmodule // acr_host_model
`default_nettype wire

// file: acr_config_regs_test.sv
`timescale 1ns/1ps
`default_nettype none
module acr_config_regs_test;
logic ref_clk, srst, wrStrobe, rdStrobe, rdValid, sampleTick, trimNegative;
logic [7:0] regAddr, chanOfConv, routeIndex;
logic [15:0] wrData, rdData, q;
logic [2:0] chanMode;
logic [1:0] clkDivCode;
logic [3:0] branchesPerChan;
logic [4:0] r1, r2, r3, r4;
logic [5:0] full_scale_trim_code;
logic [6:0] trimMagnitude;
int mismatches = 0, compares = 0, cycles = 0, n, i;
acr_config_regs u_acr_config_regs (.ref_clk(ref_clk), .srst(srst), .wrStrobe(wrStrobe), .rdStrobe(rdStrobe),
    .regAddr(regAddr), .wrData(wrData), .rdData(rdData), .rdValid(rdValid), .chanMode(chanMode),
    .clkDivCode(clkDivCode), .sampleTick(sampleTick), .branchesPerChan(branchesPerChan), .chanOfConv(chanOfConv),
    .route_sel_conv_one(r1), .route_sel_conv_two(r2), .route_sel_conv_three(r3), .route_sel_conv_four(r4),
    .routeIndex(routeIndex), .full_scale_trim_code(full_scale_trim_code), .trimMagnitude(trimMagnitude),
    .trimNegative(trimNegative));
acr_host_model host (.ref_clk(ref_clk), .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .regAddr(regAddr),
    .wrData(wrData), .rdData(rdData), .rdValid(rdValid));
// ==========
// Clock, timeout and checking
initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
end
always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
        mismatches = mismatches + 1;
        final_report;
    end
end
task final_report;
    if (mismatches == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
endtask
task chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
        mismatches++;
        $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
endtask
task cyc(input int k);
    repeat (k) @(posedge ref_clk);
    #1;
endtask
// ==========
// Scenarios
initial begin
    srst = 1'b1;
    cyc(20);
    srst = 1'b0;
    cyc(1);
    host.rd(8'h31, q); chk(q, 16'h0004);
    host.rd(8'h3A, q); chk(q, 16'h0402);
    host.rd(8'h3B, q); chk(q, 16'h1008);
    host.rd(8'h55, q); chk(q, 16'h0020);
    host.rd(8'h40, q); chk(q, 16'h0000);
    chk({chanOfConv, routeIndex}, 16'hE4E4);
    for (i = 0; i < 3; i++) begin
        host.wr(8'h31, {6'h00, i[1:0], 5'h00, 3'h1 << i});
        cyc(1);
        chk(branchesPerChan, 16'h8 >> i);
        chk(chanOfConv, i == 0 ? 16'h00 : i == 1 ? 16'h50 : 16'hE4);
    end
    for (i = 0; i < 4; i++) begin
        host.wr(8'h31, {6'h00, i[1:0], 8'h04});
        cyc(4);
        n = 0;
        repeat (32) begin
            @(posedge ref_clk);
            #1 n += sampleTick;
        end
        chk(n, 32 >> i);
    end
    host.wr(8'h3A, 16'h0810);
    chk({r2, r1}, 16'h0110);
    host.wr(8'h3B, 16'h0303);
    cyc(1);
    chk(routeIndex, 16'h0B);
    host.rd(8'h3B, q); chk(q, 16'h0202);
    for (i = 0; i < 64; i += 31) begin
        host.wr(8'h55, {10'h000, i[5:0]});
        cyc(1);
        chk({trimNegative, trimMagnitude}, i < 32 ? 16'h80 | (32 - i) : i - 32);
    end
    host.wr(8'h00, 16'h0000);
    chk(full_scale_trim_code, 16'h3E);
    host.wr(8'h00, 16'h0001);
    chk({chanMode, 1'b0, clkDivCode, r1, r4}, 16'h8050);
    chk({r3, r2}, 16'h0104);
    chk(full_scale_trim_code, 16'h0020);
    host.rd(8'h00, q); chk(q, 16'h0000);
    final_report;
end
endmodule // acr_config_regs_test
`default_nettype wire
